/* rtl/cfe_pkg.sv */
// Shared constants and types for the codec front end digital path.
`default_nettype none
package cfe_pkg;

	// Register port geometry and map.
	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_GAIN = 3'h1;
	localparam logic [2:0] ADDR_DAC = 3'h2;
	localparam logic [2:0] ADDR_ADC = 3'h3;
	localparam logic [2:0] ADDR_STATUS = 3'h4;

	// Field positions.
	localparam int GAIN_LSB = 0;
	localparam int GAIN_W = 3;
	localparam int STAT_ADC_NEW = 0;
	localparam int STAT_DAC_REUSED = 1;
	localparam int STAT_W = 2;

	// Sample rate codes.
	localparam logic [1:0] RATE_64K = 2'h0;
	localparam logic [1:0] RATE_32K = 2'h1;
	localparam logic [1:0] RATE_16K = 2'h2;
	localparam logic [1:0] RATE_8K = 2'h3;

	// Timing: nominal master clock, modulator oversampling, sinc length.
	localparam int MCLK_HZ = 16384000;
	localparam int CLK_DIV = 1;
	localparam int MOD_OSR = 8;
	localparam int MOD_CNT_W = $clog2(MOD_OSR);
	localparam int DIV_CNT_W = 8;
	localparam int BASE_N = 32;
	localparam int N_CNT_W = 8;
	localparam int BASE_N_LOG2 = 5;

	// Datapath widths and limits.
	localparam int DEC_W = 27;
	localparam int INT_W = 34;
	localparam int DSM_W = 18;
	localparam int SAMPLE_W = 15;
	localparam int SAMPLE_MAX = 16383;
	localparam int SAMPLE_MIN = -16384;
	localparam logic DATA_FLAG = 1'b0;
	localparam logic [15:0] DAC_FS_POS = 16'h7FFF;
	localparam logic [15:0] DAC_FS_NEG = 16'h8000;

	// Input gain in dB per code, code 7 in the top six bits.
	localparam logic [47:0] GAIN_DB_TABLE = {6'h26, 6'h20, 6'h1A, 6'h14,
		6'h12, 6'h0C, 6'h06, 6'h00};

	typedef struct packed {
		logic [1:0] rate;
		logic se_pick;
		logic single_ended;
		logic invert;
		logic loopback;
	} cfe_cfg_type;

	typedef struct packed {
		logic flag;
		logic [SAMPLE_W-1:0] sample;
	} cfe_word_type;

	localparam int CFG_W = $bits(cfe_cfg_type);
	localparam cfe_cfg_type CFG_RESET = '0;
	localparam logic [GAIN_W-1:0] GAIN_RESET = 3'h0;
	localparam logic [DATA_W-1:0] DAC_RESET = 16'h0000;

endpackage
`default_nettype wire

/* rtl/cfe_top.sv */
// Digital encoder and decoder path of a single channel voiceband codec.
//
// Operation
// - The encoder bitstream enters the decimator once every eight divided clocks.
// - The input gain stage sampling strobe runs at one eighth of the divided clock.
// - A sinc-cubed decimator yields 64, 32, 16 or 8 kHz samples at 16.384 MHz.
// - Decimation widens the single bit stream into a high resolution word.
// - A sinc-cubed interpolator raises decoder samples to the modulator rate.
// - A digital sigma-delta modulator turns interpolated words into one bit.
// - A 3-bit gain code in bits 0 to 2 selects 0 to 38 dB of input gain.
// - The encoder input is either the input pins or the decoder loop-back.
// - The inversion option flips the polarity of the differential input.
// - Single-ended mode converts whichever input pin software selects.
// - Sample traffic passes through the codec serial port; encoder words can also be read at ADDR_ADC.
// - Encoder words are 15-bit twos complement plus a control or data flag.
// - Decoder words are twos complement, 0x7FFF full positive, 0x8000 negative.
// - With no new decoder word in a sample period the last one is reused.
`timescale 1ns/1ps
`default_nettype none
module cfe_top #(
	parameter int CLK_DIV = cfe_pkg::CLK_DIV
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [cfe_pkg::ADDR_W-1:0] addr_i,
	input wire logic [cfe_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [cfe_pkg::DATA_W-1:0] rdata_o,
	input wire logic mod_bit_i,
	input wire logic [cfe_pkg::DATA_W-1:0] sport_rx_word_i,
	input wire logic sport_rx_valid_i,
	output cfe_pkg::cfe_word_type sport_tx_word_o,
	output logic sport_tx_valid_o,
	output logic dac_bit_o,
	output logic sc_sample_o,
	output logic loopback_sel_o,
	output logic invert_o,
	output logic single_ended_o,
	output logic se_pick_o,
	output logic [cfe_pkg::GAIN_W-1:0] gain_code_o,
	output logic [5:0] gain_db_o
);

	cfe_pkg::cfe_cfg_type cfg_q;
	logic [cfe_pkg::GAIN_W-1:0] gain_q;
	logic [cfe_pkg::DATA_W-1:0] dac_word_q;
	logic got_new_q;
	logic [cfe_pkg::STAT_W-1:0] stat_q;
	logic [cfe_pkg::DIV_CNT_W-1:0] div_cnt_q;
	logic [cfe_pkg::MOD_CNT_W-1:0] mod_cnt_q;
	logic [cfe_pkg::N_CNT_W-1:0] samp_cnt_q;
	logic [cfe_pkg::N_CNT_W-1:0] n_last;
	logic dm_tick;
	logic mod_tick;
	logic samp_tick;
	logic bit_meta_q;
	logic bit_sync_q;
	logic enc_bit;
	logic ctrl_wr;

	assign ctrl_wr = wr_i && addr_i == cfe_pkg::ADDR_CTRL;

	// Configuration state. The gain register shares its layout with the
	// analog gain selector so software sees exactly what drives the stage.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cfg_q <= cfe_pkg::CFG_RESET;
			gain_q <= cfe_pkg::GAIN_RESET;
		end else if (wr_i) begin
			if (addr_i == cfe_pkg::ADDR_CTRL) begin
				cfg_q <= cfe_pkg::cfe_cfg_type'(wdata_i[cfe_pkg::CFG_W-1:0]);
			end
			if (addr_i == cfe_pkg::ADDR_GAIN) begin
				gain_q <= wdata_i[cfe_pkg::GAIN_LSB +: cfe_pkg::GAIN_W];
			end
		end
	end

	// Analog front end controls, all straight from flops.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			loopback_sel_o <= 1'b0;
			invert_o <= 1'b0;
			single_ended_o <= 1'b0;
			se_pick_o <= 1'b0;
			gain_code_o <= cfe_pkg::GAIN_RESET;
			gain_db_o <= 6'h00;
		end else begin
			loopback_sel_o <= cfg_q.loopback;
			invert_o <= cfg_q.invert;
			single_ended_o <= cfg_q.single_ended;
			se_pick_o <= cfg_q.se_pick;
			gain_code_o <= gain_q;
			gain_db_o <= cfe_pkg::GAIN_DB_TABLE[6*gain_q +: 6];
		end
	end

	// Timebase: divided clock, modulator rate and output sample rate.
	assign dm_tick = div_cnt_q == cfe_pkg::DIV_CNT_W'(CLK_DIV - 1);
	assign mod_tick = dm_tick && (&mod_cnt_q);
	assign samp_tick = mod_tick && samp_cnt_q == n_last;

	always_comb begin
		case (cfg_q.rate)
			cfe_pkg::RATE_64K: n_last = 8'h1F;
			cfe_pkg::RATE_32K: n_last = 8'h3F;
			cfe_pkg::RATE_16K: n_last = 8'h7F;
			cfe_pkg::RATE_8K: n_last = 8'hFF;
			default: n_last = 8'h1F;
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_cnt_q <= '0;
			mod_cnt_q <= '0;
			samp_cnt_q <= '0;
		end else begin
			div_cnt_q <= dm_tick ? '0 : div_cnt_q + 1'b1;
			if (dm_tick) begin
				mod_cnt_q <= mod_cnt_q + 1'b1;
			end
			// A rate change restarts the sample phase so no period is cut short.
			if (ctrl_wr || samp_tick) begin
				samp_cnt_q <= '0;
			end else if (mod_tick) begin
				samp_cnt_q <= samp_cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sc_sample_o <= 1'b0;
		end else begin
			sc_sample_o <= mod_tick;
		end
	end

	// The modulator comparator is asynchronous to this clock.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bit_meta_q <= 1'b0;
			bit_sync_q <= 1'b0;
		end else begin
			bit_meta_q <= mod_bit_i;
			bit_sync_q <= bit_meta_q;
		end
	end

	// Loop-back substitutes the decoder bitstream; inversion flips the sign.
	assign enc_bit = cfg_q.loopback ? dac_bit_o :
		(cfg_q.invert ? ~bit_sync_q : bit_sync_q);

	// Sinc-cubed decimator: integrators at modulator rate, combs at output.
	logic signed [cfe_pkg::DEC_W-1:0] i1_q, i2_q, i3_q;
	logic signed [cfe_pkg::DEC_W-1:0] z1_q, z2_q, z3_q;
	logic signed [cfe_pkg::DEC_W-1:0] enc_x, d1, d2, d3, dec_scaled;
	logic [3:0] dec_shift;
	logic [cfe_pkg::SAMPLE_W-1:0] adc_sample;

	assign enc_x = enc_bit ? cfe_pkg::DEC_W'(1) : cfe_pkg::DEC_W'(-1);
	assign d1 = i3_q - z1_q;
	assign d2 = d1 - z2_q;
	assign d3 = d2 - z3_q;
	// Gain is N cubed, so the shift tracks three bits per rate step.
	assign dec_shift = 4'(3 * int'(cfg_q.rate)) + 4'h1;
	assign dec_scaled = d3 >>> dec_shift;

	always_comb begin
		if (dec_scaled > cfe_pkg::DEC_W'(cfe_pkg::SAMPLE_MAX)) begin
			adc_sample = cfe_pkg::SAMPLE_W'(cfe_pkg::SAMPLE_MAX);
		end else if (dec_scaled < cfe_pkg::DEC_W'(cfe_pkg::SAMPLE_MIN)) begin
			adc_sample = cfe_pkg::SAMPLE_W'(cfe_pkg::SAMPLE_MIN);
		end else begin
			adc_sample = dec_scaled[cfe_pkg::SAMPLE_W-1:0];
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			i1_q <= '0;
			i2_q <= '0;
			i3_q <= '0;
		end else if (mod_tick) begin
			i1_q <= i1_q + enc_x;
			i2_q <= i2_q + i1_q;
			i3_q <= i3_q + i2_q;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			z1_q <= '0;
			z2_q <= '0;
			z3_q <= '0;
			sport_tx_word_o <= '0;
			sport_tx_valid_o <= 1'b0;
		end else begin
			sport_tx_valid_o <= samp_tick;
			if (samp_tick) begin
				z1_q <= i3_q;
				z2_q <= d1;
				z3_q <= d2;
				sport_tx_word_o.flag <= cfe_pkg::DATA_FLAG;
				sport_tx_word_o.sample <= adc_sample;
			end
		end
	end

	// Decoder word holding: the last word stands until a new one arrives.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dac_word_q <= cfe_pkg::DAC_RESET;
			got_new_q <= 1'b0;
		end else begin
			if (sport_rx_valid_i) begin
				dac_word_q <= sport_rx_word_i;
			end
			if (sport_rx_valid_i) begin
				got_new_q <= 1'b1;
			end else if (samp_tick) begin
				got_new_q <= 1'b0;
			end
		end
	end

	// Sinc-cubed interpolator: combs at sample rate, zero stuffing, then
	// integrators at modulator rate. Gain is N squared.
	logic signed [cfe_pkg::INT_W-1:0] dac_x, g1, g2, g3;
	logic signed [cfe_pkg::INT_W-1:0] y1_q, y2_q, y3_q, comb_q;
	logic signed [cfe_pkg::INT_W-1:0] j1_q, j2_q, j3_q, int_in, int_scaled;
	logic stuff_q;
	logic [4:0] int_shift;
	logic signed [cfe_pkg::DATA_W-1:0] interp_word;

	assign dac_x = cfe_pkg::INT_W'(signed'(dac_word_q));
	assign g1 = dac_x - y1_q;
	assign g2 = g1 - y2_q;
	assign g3 = g2 - y3_q;
	assign int_in = stuff_q ? comb_q : '0;
	assign int_shift = 5'(2 * (cfe_pkg::BASE_N_LOG2 + int'(cfg_q.rate)));
	assign int_scaled = j3_q >>> int_shift;

	always_comb begin
		if (int_scaled > cfe_pkg::INT_W'(signed'(cfe_pkg::DAC_FS_POS))) begin
			interp_word = signed'(cfe_pkg::DAC_FS_POS);
		end else if (int_scaled < cfe_pkg::INT_W'(signed'(cfe_pkg::DAC_FS_NEG))) begin
			interp_word = signed'(cfe_pkg::DAC_FS_NEG);
		end else begin
			interp_word = int_scaled[cfe_pkg::DATA_W-1:0];
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			y1_q <= '0;
			y2_q <= '0;
			y3_q <= '0;
			comb_q <= '0;
			stuff_q <= 1'b0;
		end else begin
			if (samp_tick) begin
				y1_q <= dac_x;
				y2_q <= g1;
				y3_q <= g2;
				comb_q <= g3;
				stuff_q <= 1'b1;
			end else if (mod_tick) begin
				stuff_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			j1_q <= '0;
			j2_q <= '0;
			j3_q <= '0;
		end else if (mod_tick) begin
			j1_q <= j1_q + int_in;
			j2_q <= j2_q + j1_q;
			j3_q <= j3_q + j2_q;
		end
	end

	// First order error feedback modulator; the accumulator stays bounded
	// because feedback is always the full scale of the same sign as the sum.
	logic signed [cfe_pkg::DSM_W-1:0] dsm_acc_q, dsm_sum, dsm_fb;
	logic dsm_bit;

	assign dsm_sum = dsm_acc_q + cfe_pkg::DSM_W'(interp_word);
	assign dsm_bit = ~dsm_sum[cfe_pkg::DSM_W-1];
	assign dsm_fb = dsm_bit ?
		cfe_pkg::DSM_W'(signed'(cfe_pkg::DAC_FS_POS)) :
		cfe_pkg::DSM_W'(signed'(cfe_pkg::DAC_FS_NEG));

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dsm_acc_q <= '0;
			dac_bit_o <= 1'b0;
		end else if (mod_tick) begin
			dsm_acc_q <= dsm_sum - dsm_fb;
			dac_bit_o <= dsm_bit;
		end
	end

	// Sticky status. A new event in the clearing cycle wins over the clear.
	logic adc_rd;
	logic [cfe_pkg::STAT_W-1:0] stat_set;
	logic [cfe_pkg::STAT_W-1:0] stat_clr;

	assign adc_rd = rd_i && addr_i == cfe_pkg::ADDR_ADC;

	always_comb begin
		stat_set = '0;
		stat_set[cfe_pkg::STAT_ADC_NEW] = samp_tick;
		stat_set[cfe_pkg::STAT_DAC_REUSED] = samp_tick && !got_new_q;
		stat_clr = '0;
		if (wr_i && addr_i == cfe_pkg::ADDR_STATUS) begin
			stat_clr = wdata_i[cfe_pkg::STAT_W-1:0];
		end
		if (adc_rd) begin
			stat_clr[cfe_pkg::STAT_ADC_NEW] = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stat_q <= '0;
		end else begin
			stat_q <= (stat_q & ~stat_clr) | stat_set;
		end
	end

	// Read data stands for exactly one cycle after the strobe.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= '0;
		end else if (rd_i) begin
			case (addr_i)
				cfe_pkg::ADDR_CTRL: rdata_o <= cfe_pkg::DATA_W'(cfg_q);
				cfe_pkg::ADDR_GAIN: rdata_o <= cfe_pkg::DATA_W'(gain_q);
				cfe_pkg::ADDR_DAC: rdata_o <= dac_word_q;
				cfe_pkg::ADDR_ADC: rdata_o <= sport_tx_word_o;
				cfe_pkg::ADDR_STATUS: rdata_o <= cfe_pkg::DATA_W'(stat_q);
				default: rdata_o <= '0;
			endcase
		end else begin
			rdata_o <= '0;
		end
	end

endmodule
`default_nettype wire

/* tb/cfe_checker_assertions.sv */
// Port checks for the codec front end digital path.
`timescale 1ns/1ps
`default_nettype none
module cfe_checker #(
	parameter int CLK_DIV = 1
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [2:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic sc_sample_o,
	input wire cfe_pkg::cfe_word_type sport_tx_word_o,
	input wire logic sport_tx_valid_o,
	input wire logic dac_bit_o,
	input wire logic loopback_sel_o,
	input wire logic invert_o,
	input wire logic single_ended_o,
	input wire logic se_pick_o,
	input wire logic [2:0] gain_code_o,
	input wire logic [5:0] gain_db_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	logic [11:0] gap_q;
	logic gw;
	logic cw;
	logic [6:0] cfg;
	assign gw = wr_i && addr_i == cfe_pkg::ADDR_GAIN;
	assign cw = wr_i && addr_i == cfe_pkg::ADDR_CTRL;
	assign cfg = {gain_code_o, se_pick_o, single_ended_o, invert_o,
		loopback_sel_o};
	// The gap saturates so a long idle spell cannot wrap into a short one.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			gap_q <= '0;
		else if (sport_tx_valid_o)
			gap_q <= '0;
		else if (gap_q != 12'hFFF)
			gap_q <= gap_q + 12'h001;
	end
	a_sc_rate: assert property (
		sc_sample_o |=> !sc_sample_o [*7] ##1 sc_sample_o)
		else $error("gain stage strobe not every 8 clocks");
	a_tx_gap: assert property (
		sport_tx_valid_o |-> int'(gap_q) >= 255 * CLK_DIV)
		else $error("encoder words closer than the decimation ratio");
	a_tx_flag: assert property (
		sport_tx_valid_o |-> sport_tx_word_o.flag == cfe_pkg::DATA_FLAG)
		else $error("encoder word not flagged as data");
	a_gain_db: assert property (
		gain_code_o == $past(gain_code_o) |->
		gain_db_o == cfe_pkg::GAIN_DB_TABLE[6 * gain_code_o +: 6])
		else $error("gain in dB does not match gain code");
	a_gain_wr: assert property (
		gw ##1 !gw |=> gain_code_o == $past(wdata_i[2:0], 2))
		else $error("gain code not taken from write");
	a_ctrl_wr: assert property (
		cw ##1 !cw |=> cfg[3:0] == $past(wdata_i[3:0], 2))
		else $error("input routing not taken from write");
	a_cfg_hold: assert property (
		!$past(cw, 2) && !$past(gw, 2) |-> $stable(cfg))
		else $error("configuration changed without a write");
	a_dac_tick: assert property (
		$changed(dac_bit_o) |=> $stable(dac_bit_o) [*7])
		else $error("decoder bit changed off the modulator rate");
	c_tx: cover property (sport_tx_valid_o);
	c_loop: cover property (loopback_sel_o && sport_tx_valid_o);
	c_gain7: cover property (gain_code_o == 3'h7);
endmodule
bind cfe_top cfe_checker #(.CLK_DIV(CLK_DIV)) i_cfe_checker (
	.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .sc_sample_o,
	.sport_tx_word_o, .sport_tx_valid_o, .dac_bit_o, .loopback_sel_o,
	.invert_o, .single_ended_o, .se_pick_o, .gain_code_o, .gain_db_o);
`default_nettype wire

/* tb/cfe_host_model.sv */
// Host serial port model that takes encoder words and feeds decoder words.
`timescale 1ns/1ps
`default_nettype none
module cfe_host_model (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic feed_i,
	input wire logic slow_i,
	input wire logic [15:0] word_i,
	input wire cfe_pkg::cfe_word_type tx_word_i,
	input wire logic tx_valid_i,
	output logic [15:0] rx_word_o,
	output logic rx_valid_o,
	output cfe_pkg::cfe_word_type last_o
);
	logic [7:0] wait_q;
	// With feed_i set, each encoder word paces one decoder word, promptly or late.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wait_q <= '0;
			rx_valid_o <= 1'b0;
			last_o <= '0;
		end else begin
			rx_valid_o <= wait_q == 8'h01;
			if (tx_valid_i) begin
				last_o <= tx_word_i;
				wait_q <= !feed_i ? 8'h00 : slow_i ? 8'hC8 : 8'h01;
			end else if (wait_q != 8'h00)
				wait_q <= wait_q - 8'h01;
		end
	end
	// Outside a transfer the lines carry no stale word.
	assign rx_word_o = rx_valid_o ? word_i : ~word_i;
endmodule
`default_nettype wire

/* tb/cfe_top_tb_top.sv */
// Self-checking bench for the codec front end digital path.
`timescale 1ns/1ps
`default_nettype none
module cfe_top_tb_top;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [2:0] addr_i;
	logic [15:0] wdata_i, rdata_o, word, rxw, v;
	logic wr_i, rd_i, mod_bit_i, feed, slow, rxv, txv, dac, sc, lb, inv, se, sp;
	logic [2:0] gcode;
	logic [5:0] gdb;
	cfe_pkg::cfe_word_type txw, last;
	int fail_count = 0;
	int tests_run = 0;
	int n, k;
	int db[8] = '{0, 6, 12, 18, 20, 26, 32, 38};
	cfe_top #(.CLK_DIV(1)) i_cfe_top (.clk_i(clk_i), .rstn_i(rstn_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .mod_bit_i(mod_bit_i), .sport_rx_word_i(rxw),
		.sport_rx_valid_i(rxv), .sport_tx_word_o(txw),
		.sport_tx_valid_o(txv), .dac_bit_o(dac), .sc_sample_o(sc),
		.loopback_sel_o(lb), .invert_o(inv), .single_ended_o(se),
		.se_pick_o(sp), .gain_code_o(gcode), .gain_db_o(gdb));
	cfe_host_model i_cfe_host_model (.clk_i(clk_i), .rstn_i(rstn_i),
		.feed_i(feed), .slow_i(slow), .word_i(word), .tx_word_i(txw),
		.tx_valid_i(txv), .rx_word_o(rxw), .rx_valid_o(rxv), .last_o(last));
	always #5 clk_i = ~clk_i;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	task automatic rdchk(input logic [2:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		chk(d, e);
	endtask
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Bounded so a silent encoder ends the run instead of hanging it.
	task automatic wait_tx(input int times);
		repeat (times) begin
			n = 0;
			do begin
				@(posedge clk_i);
				#1 n++;
			end while (txv !== 1'b1 && n < 5000);
			if (n >= 5000) begin
				fail_count++;
				give_verdict();
			end
		end
	endtask
	task automatic ones();
		k = 0;
		repeat (512) begin
			@(posedge clk_i);
			#1 k += int'(dac);
		end
	endtask
	initial begin
		addr_i = 3'h0;
		wdata_i = 16'h0000;
		wr_i = 1'b0;
		rd_i = 1'b0;
		mod_bit_i = 1'b1;
		feed = 1'b1;
		slow = 1'b0;
		word = 16'h7FFF;
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		for (int a = 0; a < 8; a++)
			rdchk(3'(a), 16'h0000);
		for (int g = 0; g < 8; g++) begin
			wr(cfe_pkg::ADDR_GAIN, 16'(g));
			repeat (2) @(posedge clk_i);
			#1 chk(16'(gcode), 16'(g));
			chk(16'(gdb), 16'(db[g]));
			rdchk(cfe_pkg::ADDR_GAIN, 16'(g));
		end
		for (int c = 0; c < 16; c++) begin
			wr(cfe_pkg::ADDR_CTRL, 16'(c));
			repeat (2) @(posedge clk_i);
			#1 chk(16'({sp, se, inv, lb}), 16'(c));
			rdchk(cfe_pkg::ADDR_CTRL, 16'(c));
		end
		for (int r = 0; r < 4; r++) begin
			wr(cfe_pkg::ADDR_CTRL, 16'(r << 4));
			// The combs need three whole periods after a rate change, so
			// only the fourth word is a settled sample.
			wait_tx(4);
			chk(16'(n), 16'h0100 << r);
			chk(16'(txw.flag), 16'h0000);
			chk(16'(txw.sample[14]), 16'h0000);
		end
		rdchk(cfe_pkg::ADDR_ADC, 16'(last));
		wr(cfe_pkg::ADDR_CTRL, 16'h0000);
		wr(cfe_pkg::ADDR_STATUS, 16'h0003);
		rdchk(cfe_pkg::ADDR_STATUS, 16'h0000);
		wait_tx(2);
		rdchk(cfe_pkg::ADDR_STATUS, 16'h0001);
		@(posedge clk_i);
		word <= 16'h8000;
		slow <= 1'b1;
		wait_tx(6);
		ones();
		chk(16'(k < 64), 16'h0001);
		@(posedge clk_i);
		word <= 16'h7FFF;
		slow <= 1'b0;
		wait_tx(6);
		ones();
		chk(16'(k > 448), 16'h0001);
		@(posedge clk_i);
		feed <= 1'b0;
		wait_tx(3);
		rd(cfe_pkg::ADDR_STATUS, v);
		chk(v & 16'h0002, 16'h0002);
		rdchk(cfe_pkg::ADDR_DAC, 16'h7FFF);
		ones();
		chk(16'(k > 448), 16'h0001);
		wr(cfe_pkg::ADDR_CTRL, 16'h0001);
		mod_bit_i <= 1'b0;
		wait_tx(4);
		chk(16'(txw.sample[14]), 16'h0000);
		wr(cfe_pkg::ADDR_CTRL, 16'h0002);
		mod_bit_i <= 1'b1;
		wait_tx(4);
		chk(16'(txw.sample[14]), 16'h0001);
		give_verdict();
	end
endmodule
`default_nettype wire
